// File: inc/sfs_pkg.sv
`default_nettype none
package sfs_pkg;

  // Command opcodes seen on the serial input.
  localparam logic [7:0] OPC_READ_STATUS  = 8'h05;
  localparam logic [7:0] OPC_WRITE_STATUS = 8'h01;

  // Field positions inside status byte one.
  localparam int BIT_LOCK = 7;
  localparam int BIT_SEQ  = 6;
  localparam int BIT_EPE  = 5;
  localparam int BIT_WPP  = 4;
  localparam int BIT_SWPH = 3;
  localparam int BIT_SWPL = 2;
  localparam int BIT_WEL  = 1;
  localparam int BIT_BUSY = 0;

  // Software protection summary encodings.
  localparam logic [1:0] SWP_NONE = 2'h0;
  localparam logic [1:0] SWP_SOME = 2'h1;
  localparam logic [1:0] SWP_ALL  = 2'h3;

  // Values after reset.
  localparam logic RST_LOCK = 1'b0;
  localparam logic RST_SEQ  = 1'b0;
  localparam logic RST_EPE  = 1'b0;
  localparam logic RST_WEL  = 1'b0;

  // Bit counts of the serial framing.
  localparam logic [3:0] CNT_OPC_LAST = 4'h7;
  localparam logic [3:0] CNT_BYTE     = 4'h8;
  localparam logic [3:0] CNT_READ_MAX = 4'hF;

  // Sequencer phases of one chip-select frame.
  typedef enum logic [1:0] {
    PH_OPCODE = 2'b00,
    PH_READ   = 2'b01,
    PH_WRITE  = 2'b10,
    PH_SKIP   = 2'b11
  } sfs_phase_t;

  // Events and levels from the rest of the device core.
  typedef struct packed {
    logic busy;
    logic seqEnter;
    logic seqExit;
    logic opEnd;
    logic opFail;
    logic welSet;
    logic welClear;
    logic anyProt;
    logic allProt;
  } sfs_core_t;

  // Write-status request handed to the protection logic.
  typedef struct packed {
    logic       apply;
    logic       lockNew;
    logic [3:0] globalBits;
    logic       globalOk;
  } sfs_wsr_t;

endpackage : sfs_pkg
`default_nettype wire

// File: hw/sfs_sync.sv
`timescale 1ns/10ps
`default_nettype none
module sfs_sync #(
  parameter int WIDTH = 4,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  // Clock and reset.
  input  wire logic             clock,
  input  wire logic             nrst,
  // Raw pins and filtered levels.
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);

  logic [WIDTH-1:0] s1_q;
  logic [WIDTH-1:0] s2_q;
  logic [WIDTH-1:0] s3_q;

  // Three stages; only the second stage reads the first.
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      s1_q <= INIT;
      s2_q <= INIT;
      s3_q <= INIT;
    end else begin
      s1_q <= din;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // A bit changes only once stages two and three agree, which rejects a one-sample glitch.
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      dout <= INIT;
    end else begin
      for (int i = 0; i < WIDTH; i++) begin
        if (s2_q[i] == s3_q[i]) begin
          dout[i] <= s2_q[i];
        end
      end
    end
  end

endmodule : sfs_sync
`default_nettype wire

// File: hw/sfs_status.sv
`timescale 1ns/10ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
module sfs_status (
  // Clock and reset.
  input  wire logic          clock,
  input  wire logic          nrst,
  // Serial pins.
  input  wire logic          csN,
  input  wire logic          sck,
  input  wire logic          si,
  input  wire logic          wpN,
  output logic               soOut,
  output logic               soOe,
  // Device core side.
  input  wire sfs_pkg::sfs_core_t core,
  output sfs_pkg::sfs_wsr_t  wsr,
  output logic               protectionLocked,
  output logic               writeEnabled
);

  //////////////////////////////////////////////////////////////////////////////
  // Pin conditioning.

  logic [3:0] pinF;
  logic       csNF;
  logic       sckF;
  logic       siF;
  logic       wpNF;
  logic       sckPrev_q;
  logic       csPrev_q;
  logic       sckRise;
  logic       sckFall;
  logic       csRelease;

  // Idle levels: chip select and write-protect high, clock low.
  sfs_sync #(
    .WIDTH (4),
    .INIT  (4'h9)
  ) u_sync (
    .clock (clock),
    .nrst  (nrst),
    .din   ({csN, sck, si, wpN}),
    .dout  (pinF)
  );

  assign csNF = pinF[3];
  assign sckF = pinF[2];
  assign siF  = pinF[1];
  assign wpNF = pinF[0];

  // Edge memory for the filtered clock and chip select.
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      sckPrev_q <= 1'b0;
      csPrev_q  <= 1'b1;
    end else begin
      sckPrev_q <= sckF;
      csPrev_q  <= csNF;
    end
  end

  // Edges only count inside a frame, so stray clocks while deselected do nothing.
  assign sckRise   = !csNF && sckF && !sckPrev_q;
  assign sckFall   = !csNF && !sckF && sckPrev_q;
  assign csRelease = csNF && !csPrev_q;

  //////////////////////////////////////////////////////////////////////////////
  // Status contents.

  logic       lock_q;
  logic       seq_q;
  logic       epe_q;
  logic       wel_q;
  logic [7:0] statusOne;
  logic [7:0] statusTwo;

  // Sector protection summary; the reserved code is never produced.
  function automatic logic [1:0] swpCode(input logic anyP, input logic allP);
    if (allP) begin
      swpCode = sfs_pkg::SWP_ALL;
    end else if (anyP) begin
      swpCode = sfs_pkg::SWP_SOME;
    end else begin
      swpCode = sfs_pkg::SWP_NONE;
    end
  endfunction : swpCode

  // Live bytes, rebuilt every cycle so repeated passes show fresh values.
  always_comb begin
    statusOne                   = 8'h00;
    statusOne[sfs_pkg::BIT_LOCK] = lock_q;
    statusOne[sfs_pkg::BIT_SEQ]  = seq_q;
    statusOne[sfs_pkg::BIT_EPE]  = epe_q;
    statusOne[sfs_pkg::BIT_WPP]  = wpNF;
    statusOne[sfs_pkg::BIT_SWPH:sfs_pkg::BIT_SWPL] = swpCode(core.anyProt, core.allProt);
    statusOne[sfs_pkg::BIT_WEL]  = wel_q;
    statusOne[sfs_pkg::BIT_BUSY] = core.busy;
    statusTwo                   = 8'h00;
    statusTwo[sfs_pkg::BIT_BUSY] = core.busy;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Command sequencer.

  sfs_pkg::sfs_phase_t phase_q;
  logic [3:0]          cnt_q;
  logic [7:0]          shift_q;
  logic [7:0]          opcode;

  assign opcode = {shift_q[6:0], siF};

  // Opcode capture on rising clock; reads are decoded whatever the busy state.
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      phase_q <= sfs_pkg::PH_OPCODE;
      cnt_q   <= 4'h0;
      shift_q <= 8'h00;
    end else if (csNF) begin
      phase_q <= sfs_pkg::PH_OPCODE;
      cnt_q   <= 4'h0;
    end else if (sckRise) begin
      unique case (phase_q)
        sfs_pkg::PH_OPCODE: begin
          shift_q <= opcode;
          if (cnt_q == sfs_pkg::CNT_OPC_LAST) begin
            cnt_q <= 4'h0;
            if (opcode == sfs_pkg::OPC_READ_STATUS) begin
              phase_q <= sfs_pkg::PH_READ;
            end else if (opcode == sfs_pkg::OPC_WRITE_STATUS) begin
              phase_q <= sfs_pkg::PH_WRITE;
            end else begin
              phase_q <= sfs_pkg::PH_SKIP;
            end
          end else begin
            cnt_q <= cnt_q + 4'h1;
          end
        end
        sfs_pkg::PH_WRITE: begin
          // Only the first data byte is kept; later bytes are ignored.
          if (cnt_q != sfs_pkg::CNT_BYTE) begin
            shift_q <= opcode;
            cnt_q   <= cnt_q + 4'h1;
          end
        end
        sfs_pkg::PH_READ: begin
        end
        sfs_pkg::PH_SKIP: begin
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Write-status completion.

  logic wsrFull;
  logic wsrDone;
  logic wpBlocks;
  logic wsrAccept;

  assign wsrFull   = cnt_q == sfs_pkg::CNT_BYTE;
  // A frame counts only once the whole opcode has arrived.
  assign wsrDone   = csRelease && phase_q == sfs_pkg::PH_WRITE;
  assign wpBlocks  = !wpNF && lock_q && !shift_q[sfs_pkg::BIT_LOCK];
  assign wsrAccept = wsrDone && wsrFull && wel_q && !wpBlocks;

  // The lock bit is the only status bit a host write loads; wsrDone also clears the write-enable latch.
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      lock_q <= sfs_pkg::RST_LOCK;
    end else if (wsrAccept) begin
      lock_q <= shift_q[sfs_pkg::BIT_LOCK];
    end
  end

  // Global protect is allowed only when the lock was clear before this write.
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      wsr <= '0;
    end else begin
      wsr.apply      <= wsrAccept;
      wsr.lockNew    <= shift_q[sfs_pkg::BIT_LOCK];
      wsr.globalBits <= shift_q[5:2];
      wsr.globalOk   <= wsrAccept && !lock_q;
    end
  end

  assign protectionLocked = lock_q;
  assign writeEnabled     = wel_q;

  //////////////////////////////////////////////////////////////////////////////
  // Hardware-maintained flags.

  // The write-enable command wins over a coincident clear, so a fresh enable is never lost.
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      wel_q <= sfs_pkg::RST_WEL;
    end else if (core.welSet) begin
      wel_q <= 1'b1;
    end else if (core.welClear || wsrDone) begin
      wel_q <= 1'b0;
    end
  end

  // Entering sequential mode wins over a coincident exit.
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      seq_q <= sfs_pkg::RST_SEQ;
    end else if (core.seqEnter) begin
      seq_q <= 1'b1;
    end else if (core.seqExit) begin
      seq_q <= 1'b0;
    end
  end

  // Aborts never pulse the end event, so they leave the error flag alone.
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      epe_q <= sfs_pkg::RST_EPE;
    end else if (core.opEnd) begin
      epe_q <= core.opFail;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Status shifter.

  logic [3:0] rdIdx_q;
  logic [7:0] snap_q;
  logic [7:0] byteNow;
  logic       firstBit;

  assign firstBit = rdIdx_q[2:0] == 3'h0;
  assign byteNow  = rdIdx_q[3] ? statusTwo : statusOne;

  // Output changes on falling clock; each byte is sampled once at its first bit.
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      rdIdx_q <= 4'h0;
      snap_q  <= 8'h00;
      soOut   <= 1'b0;
      soOe    <= 1'b0;
    end else if (csNF) begin
      rdIdx_q <= 4'h0;
      soOe    <= 1'b0;
    end else if (sckFall && phase_q == sfs_pkg::PH_READ) begin
      soOe    <= 1'b1;
      rdIdx_q <= rdIdx_q + 4'h1;
      if (firstBit) begin
        soOut  <= byteNow[7];
        snap_q <= {byteNow[6:0], 1'b0};
      end else begin
        soOut  <= snap_q[7];
        snap_q <= {snap_q[6:0], 1'b0};
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Checks.

  AST_CS_RELEASE_HIZ: assert property (@(posedge clock) disable iff (!nrst)
    csNF |=> !soOe)
    else $error("serial output still driven after chip select release");

  AST_READ_ENTER: assert property (@(posedge clock) disable iff (!nrst)
    (phase_q == sfs_pkg::PH_OPCODE && sckRise && cnt_q == sfs_pkg::CNT_OPC_LAST
     && opcode == sfs_pkg::OPC_READ_STATUS) |=> phase_q == sfs_pkg::PH_READ)
    else $error("read status opcode not decoded");

  AST_READ_WRAP: assert property (@(posedge clock) disable iff (!nrst)
    (sckFall && phase_q == sfs_pkg::PH_READ && rdIdx_q == sfs_pkg::CNT_READ_MAX) |=> rdIdx_q == 4'h0)
    else $error("status readout did not wrap after byte two");

  AST_FIRST_BIT: assert property (@(posedge clock) disable iff (!nrst)
    (sckFall && phase_q == sfs_pkg::PH_READ && rdIdx_q == 4'h0) |=> soOut == $past(statusOne[7]) && soOe)
    else $error("first status bit is not byte one bit 7");

  AST_LOCK_WP: assert property (@(posedge clock) disable iff (!nrst)
    (!wpNF && lock_q) |=> lock_q)
    else $error("lock bit cleared while write-protect asserted");

  AST_LOCK_ONLY_WRSR: assert property (@(posedge clock) disable iff (!nrst)
    !wsrDone |=> $stable(lock_q))
    else $error("lock bit changed outside a write-status frame");

  AST_EPE_ABORT: assert property (@(posedge clock) disable iff (!nrst)
    !core.opEnd |=> $stable(epe_q))
    else $error("error flag changed without an operation end");

  AST_WEL_CLEAR: assert property (@(posedge clock) disable iff (!nrst)
    (core.welClear && !core.welSet) |=> !wel_q)
    else $error("write-enable latch not cleared");

  AST_WSR_WEL: assert property (@(posedge clock) disable iff (!nrst)
    (wsrDone && !core.welSet) |=> !wel_q && (wsr.apply == $past(wsrAccept)))
    else $error("write-status release handled wrongly");

  AST_GLOBAL_LOCKED: assert property (@(posedge clock) disable iff (!nrst)
    (wsrDone && lock_q) |=> !wsr.globalOk)
    else $error("global protect allowed while locked");

  AST_SWP_ALL: assert property (@(posedge clock) disable iff (!nrst)
    core.allProt |-> statusOne[3:2] == sfs_pkg::SWP_ALL && statusOne[4] == wpNF)
    else $error("protection summary wrong");

  AST_EPE_UPDATE: assert property (@(posedge clock) disable iff (!nrst)
    core.opEnd |=> epe_q == $past(core.opFail))
    else $error("error flag not refreshed at operation end");

  AST_BUSY_BYTES: assert property (@(posedge clock) disable iff (!nrst)
    statusOne[sfs_pkg::BIT_BUSY] == core.busy && statusTwo == {7'h00, core.busy})
    else $error("busy flag missing from a status byte");

  AST_WSR_SHORT: assert property (@(posedge clock) disable iff (!nrst)
    (wsrDone && !wsrFull) |=> !wsr.apply && $stable(lock_q))
    else $error("incomplete write-status data byte was applied");

  AST_WEL_KEEP: assert property (@(posedge clock) disable iff (!nrst)
    (csRelease && (phase_q == sfs_pkg::PH_OPCODE || phase_q == sfs_pkg::PH_SKIP) && wel_q
     && !core.welClear) |=> wel_q)
    else $error("write-enable latch lost on an incomplete or unknown opcode");

endmodule : sfs_status
`default_nettype wire

// File: tb/sfs_spi_host.sv
`timescale 1ns/10ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// Serial host on the far side of the link, mode 0: the serial clock idles low and stands still between frames.
module sfs_spi_host (
  // Link pins.
  output logic      csN,
  output logic      sck,
  output logic      si,
  input  wire logic soOut,
  input  wire logic soOe
);
  logic soLast = 1'b0;
  logic soLine;

  // A released line shows the inverse of its last driven level, so a float never reads as data.
  always @(soOut or soOe) if (soOe) soLast = soOut;
  always_comb soLine = soOe ? soOut : ~soLast;

  // Idle pins from time zero.
  initial begin
    csN = 1'b1;
    sck = 1'b0;
    si = 1'b0;
  end

  // Select the device and leave time for its pin filter.
  task automatic open_frame();
    csN = 1'b0;
    #100;
  endtask : open_frame

  // Release select and keep it high long enough before the next frame.
  task automatic close_frame();
    #100;
    csN = 1'b1;
    si = ~si;
    #200;
  endtask : close_frame

  // Shift n bits msb first; data changes on the falling edge, output is taken at the rising edge.
  task automatic shift(input logic [7:0] tx, input int n, output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 7; i > 7 - n; i--) begin
      si = tx[i];
      #62.5;
      sck = 1'b1;
      rx[i] = soLine;
      #62.5;
      sck = 1'b0;
    end
  endtask : shift
endmodule : sfs_spi_host
`default_nettype wire

// File: tb/serial_flash_status_logic_test.sv
`timescale 1ns/10ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// Drives status reads and writes through the host model and checks the status byte against a bench model.
module serial_flash_status_logic_test;
  localparam int P_SEQIN  = 7;
  localparam int P_SEQOUT = 6;
  localparam int P_END    = 5;
  localparam int P_WSET   = 3;
  localparam int P_WCLR   = 2;

  logic               clock;
  logic               nrst;
  logic               csN;
  logic               sck;
  logic               si;
  logic               wpN;
  logic               soOut;
  logic               soOe;
  sfs_pkg::sfs_core_t core;
  sfs_pkg::sfs_wsr_t  wsr;
  sfs_pkg::sfs_wsr_t  seenWsr;
  logic               protectionLocked;
  logic               writeEnabled;
  logic               lockE;
  logic               seqE;
  logic               epeE;
  logic               welE;
  logic [7:0]         b1;
  int                 fails;
  int                 n_tests;
  int                 nApply;
  int                 expApply;

  sfs_status dut_u (.clock(clock), .nrst(nrst), .csN(csN), .sck(sck), .si(si), .wpN(wpN), .soOut(soOut),
    .soOe(soOe), .core(core), .wsr(wsr), .protectionLocked(protectionLocked), .writeEnabled(writeEnabled));
  sfs_spi_host host_u (.csN(csN), .sck(sck), .si(si), .soOut(soOut), .soOe(soOe));

  // Free-running system clock.
  always #5 clock = ~clock;

  // Count every write request handed to the protection logic and keep the latest one.
  always @(posedge clock) if (wsr.apply === 1'b1) begin
    nApply++;
    seenWsr = wsr;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Expected status byte one from the bench model and the core levels.
  function automatic logic [7:0] exp1();
    return {lockE, seqE, epeE, wpN, (core.allProt ? 2'h3 : {1'b0, core.anyProt}), welE, core.busy};
  endfunction : exp1

  task automatic check(input string name, input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e) begin
      $display("BAD %s expected %h seen %h", name, e, g);
      fails++;
    end
  endtask : check

  task automatic final_report();
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : final_report

  // One full status read of both bytes, plus the level outputs.
  task automatic read_check(input string name);
    logic [7:0] b2;
    host_u.open_frame();
    host_u.shift(sfs_pkg::OPC_READ_STATUS, 8, b1);
    host_u.shift(8'h00, 8, b1);
    host_u.shift(8'h00, 8, b2);
    host_u.close_frame();
    check(name, exp1(), b1);
    check("byte2", {7'h00, core.busy}, b2);
    check("lockOut", {7'h00, lockE}, {7'h00, protectionLocked});
    check("welOut", {7'h00, welE}, {7'h00, writeEnabled});
  endtask : read_check

  // One-cycle event pulse from the core, mirrored in the bench model.
  task automatic ev(input int pos);
    @(posedge clock);
    #1 core[pos] = 1'b1;
    @(posedge clock);
    #1 core[pos] = 1'b0;
    case (pos)
      P_SEQIN: seqE = 1'b1;
      P_SEQOUT: seqE = 1'b0;
      P_END: epeE = core.opFail;
      P_WSET: welE = 1'b1;
      default: welE = 1'b0;
    endcase
  endtask : ev

  // Write-status frame of n data bits; acc says whether the lock may change, ok whether a global op may run.
  task automatic wr(input logic [7:0] data, input int n, input logic acc, input logic ok);
    host_u.open_frame();
    host_u.shift(sfs_pkg::OPC_WRITE_STATUS, 8, b1);
    host_u.shift(data, n, b1);
    host_u.close_frame();
    welE = 1'b0;
    if (acc) begin
      lockE = data[7];
      expApply++;
      check("wsr", {1'b1, data[7], data[5:2], ok}, seenWsr);
    end
    check("applies", 8'(expApply), 8'(nApply));
    read_check("afterWrite");
  endtask : wr

  ////////////////////////////////////////////////////////////////////////////////
  // Stops a hung run; the tests take about a quarter of this.
  initial begin
    #400000;
    fails++;
    final_report();
  end

  // Main sequence.
  initial begin
    clock = 1'b0;
    nrst = 1'b0;
    wpN = 1'b1;
    core = '0;
    core.anyProt = 1'b1;
    core.allProt = 1'b1;
    {lockE, seqE, epeE, welE} = 4'h0;
    {fails, n_tests, nApply, expApply} = '0;
    repeat (5) @(posedge clock);
    #1 nrst = 1'b1;
    repeat (5) @(posedge clock);
    #1;
    check("soOeIdle", 8'h00, {7'h00, soOe});
    read_check("reset");
    for (int k = 0; k < 3; k++) begin
      #1 {core.anyProt, core.allProt} = (k == 0) ? 2'h0 : (k == 1) ? 2'h2 : 2'h3;
      read_check("swp");
    end
    ev(P_WSET);
    read_check("welSet");
    ev(P_SEQIN);
    read_check("seqOn");
    core.opFail = 1'b1;
    read_check("failNoEnd");
    ev(P_END);
    read_check("epeSet");
    core.opFail = 1'b0;
    ev(P_SEQOUT);
    ev(P_END);
    read_check("epeClr");
    ev(P_WCLR);
    // Busy read that wraps into a second pass while busy falls.
    core.busy = 1'b1;
    host_u.open_frame();
    host_u.shift(sfs_pkg::OPC_READ_STATUS, 8, b1);
    host_u.shift(8'h00, 8, b1);
    check("busyB1", exp1(), b1);
    host_u.shift(8'h00, 8, b1);
    check("busyB2", 8'h01, b1);
    @(posedge clock);
    #1 core.busy = 1'b0;
    host_u.shift(8'h00, 8, b1);
    check("wrapB1", exp1(), b1);
    host_u.shift(8'h00, 3, b1);
    host_u.close_frame();
    check("soOeCut", 8'h00, {7'h00, soOe});
    wr(8'h80, 8, 1'b0, 1'b0);
    ev(P_WSET);
    wr(8'hBC, 8, 1'b1, 1'b1);
    ev(P_WSET);
    wr(8'h7F, 8, 1'b1, 1'b0);
    wpN = 1'b0;
    ev(P_WSET);
    wr(8'h80, 8, 1'b1, 1'b1);
    ev(P_WSET);
    wr(8'h00, 8, 1'b0, 1'b0);
    wpN = 1'b1;
    ev(P_WSET);
    wr(8'h00, 4, 1'b0, 1'b0);
    ev(P_WSET);
    host_u.open_frame();
    host_u.shift(sfs_pkg::OPC_WRITE_STATUS, 4, b1);
    host_u.close_frame();
    host_u.open_frame();
    host_u.shift(8'hAB, 8, b1);
    host_u.shift(8'h00, 8, b1);
    host_u.close_frame();
    read_check("welKept");
    ev(P_WCLR);
    read_check("welClr");
    // A second reset in mid-run must drop every flag set by the host or the core.
    ev(P_WSET);
    ev(P_SEQIN);
    core.opFail = 1'b1;
    ev(P_END);
    core.opFail = 1'b0;
    read_check("preReset2");
    @(posedge clock);
    #1 nrst = 1'b0;
    repeat (2) @(posedge clock);
    #1 nrst = 1'b1;
    {lockE, seqE, epeE, welE} = 4'h0;
    repeat (5) @(posedge clock);
    #1;
    read_check("reset2");
    final_report();
  end
endmodule : serial_flash_status_logic_test
`default_nettype wire
